// *** hw/cpe_cfg.svh ***
// Register offsets, field positions, reset values and scaling constants.
`ifndef CPE_CFG_SVH
`define CPE_CFG_SVH

// ------------------------------------------------------------------
// Register pointer values
// ------------------------------------------------------------------
`define CPE_ADDR_CFG      8'h00
`define CPE_ADDR_SHUNT    8'h01
`define CPE_ADDR_RAIL     8'h02
`define CPE_ADDR_POWER    8'h03
`define CPE_ADDR_CURRENT  8'h04
`define CPE_ADDR_SCALE    8'h05

// ------------------------------------------------------------------
// Configuration fields and reset values
// ------------------------------------------------------------------
`define CPE_CFG_AVG_LSB   9
`define CPE_CFG_RCT_LSB   6
`define CPE_CFG_SCT_LSB   3
`define CPE_CFG_MODE_LSB  0
`define CPE_CFG_RESET     16'h4127
`define CPE_SCALE_RESET   16'h0000

// ------------------------------------------------------------------
// Scaling
// ------------------------------------------------------------------
`define CPE_CUR_DIV       2048
`define CPE_PWR_DIV       20000
`define CPE_PWR_RATIO     25
`define CPE_RAIL_LSB_UV   1250
`define CPE_SHUNT_LSB_NV  2500

`endif

// *** hw/cpe_engine.sv ***
// Current and power scaling engine with its register file.
//
// What this block does
// [RULE1] Current equals shunt code times scale factor, divided by 2048.
// [RULE2] Power equals current magnitude times rail code, divided by 20000.
// [RULE3] Power step is fixed at 25 current steps, not programmable.
// [RULE4] Current and power results read zero while no scale factor is loaded.
// [RULE5] After a scale factor write, later samples refresh current and power.
// [RULE6] Rail code counts in steps of 1.25 mV.
// [RULE7] Rail result top bit always reads zero.
// [RULE8] Shunt code counts in steps of 2.5 uV.
// [RULE9] Pointers: config 00, shunt 01, rail 02, power 03, current 04, scale 05.
// [RULE10] Config sets shunt time, rail time and averaging count independently.
// [RULE11] Host derives scale factor as 0.00512 over current step times shunt.
// [RULE12] Host may rescale the factor by measured over reported current.
// [RULE13] Current follows each shunt sample; power follows each rail sample.
// [RULE14] With averaging, sums accumulate; averages load after the last sample.
// [RULE15] Products are full width; quotients are truncated to 16 bits.
// [RULE16] Config and scale are read-write; result registers are read-only.
`timescale 1ns/1ps
`default_nettype none
`include "cpe_cfg.svh"

module cpe_engine #(
  parameter int AVG_BITS = 10
) (
  input  wire logic                     core_clk,
  input  wire logic                     reset_n,
  input  wire logic [7:0]               reg_addr,
  input  wire logic                     reg_wr_en,
  input  wire logic [15:0]              reg_wr_data,
  input  wire logic                     reg_rd_en,
  output logic      [15:0]              reg_rd_data,
  output logic                          reg_rd_valid,
  input  wire logic                     shunt_done,
  input  wire logic [15:0]              shunt_code,
  input  wire logic                     rail_done,
  input  wire logic [14:0]              rail_sense_code,
  output cpe_pkg::cpe_sel_t             shunt_ct_sel,
  output cpe_pkg::cpe_sel_t             rail_ct_sel,
  output cpe_pkg::cpe_sel_t             avg_sel,
  output cpe_pkg::cpe_sel_t             op_mode,
  output logic                          results_loaded
);

  // ------------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------------
  if (AVG_BITS != 10) begin : g_bad_avg
    $error("AVG_BITS must be 10 to hold 1024 samples");
  end
  if (`CPE_RAIL_LSB_UV * `CPE_PWR_DIV != `CPE_PWR_RATIO * 1000000) begin : g_bad_ratio
    $error("Power step is not 25 current steps");  // RULE3
  end

  localparam int AW = 16 + AVG_BITS;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  cpe_pkg::cpe_word_t     cfg_ff, nxt_cfg;
  cpe_pkg::cpe_word_t     scale_ff, nxt_scale;
  cpe_pkg::cpe_word_t     shunt_reg_ff, nxt_shunt_reg;
  cpe_pkg::cpe_word_t     rail_reg_ff, nxt_rail_reg;
  cpe_pkg::cpe_word_t     current_ff, nxt_current;
  cpe_pkg::cpe_word_t     power_ff, nxt_power;
  cpe_pkg::cpe_word_t     cur_last_ff, nxt_cur_last;
  logic signed [AW-1:0]   shunt_acc_ff, nxt_shunt_acc;
  logic signed [AW-1:0]   cur_acc_ff, nxt_cur_acc;
  logic [AW-1:0]          rail_acc_ff, nxt_rail_acc;
  logic [AW-1:0]          pwr_acc_ff, nxt_pwr_acc;
  logic [AVG_BITS-1:0]    cnt_ff, nxt_cnt;
  cpe_pkg::cpe_word_t     rd_data_ff, nxt_rd_data;
  logic                   rd_valid_ff, nxt_rd_valid;
  logic                   loaded_ff, nxt_loaded;

  logic signed [32:0]     cur_prod_c;
  logic signed [32:0]     cur_quo_c;
  cpe_pkg::cpe_word_t     cur_calc_c;
  cpe_pkg::cpe_word_t     cur_abs_c;
  logic [30:0]            pwr_prod_c;
  logic [30:0]            pwr_quo_c;
  cpe_pkg::cpe_word_t     pwr_calc_c;
  logic [3:0]             avg_shift_c;
  logic [AVG_BITS-1:0]    last_cnt_c;
  logic signed [AW-1:0]   shunt_sum_c;
  logic signed [AW-1:0]   cur_sum_c;
  logic [AW-1:0]          rail_sum_c;
  logic [AW-1:0]          pwr_sum_c;
  logic signed [AW-1:0]   shunt_avg_c;
  logic signed [AW-1:0]   cur_avg_c;
  logic [AW-1:0]          rail_avg_c;
  logic [AW-1:0]          pwr_avg_c;

  // Averaging code to log2 of the sample count: 1,4,16,64,128,256,512,1024.
  function automatic logic [3:0] avg_log2(input cpe_pkg::cpe_sel_t code);
    logic [3:0] r;
    unique case (code)
      3'h0: r = 4'h0;
      3'h1: r = 4'h2;
      3'h2: r = 4'h4;
      3'h3: r = 4'h6;
      3'h4: r = 4'h7;
      3'h5: r = 4'h8;
      3'h6: r = 4'h9;
      3'h7: r = 4'ha;
    endcase
    return r;
  endfunction

  // ------------------------------------------------------------------
  // Arithmetic
  // ------------------------------------------------------------------
  always_comb begin
    cur_prod_c  = $signed(shunt_code) * $signed({1'b0, scale_ff});  // RULE15
    cur_quo_c   = cur_prod_c / 33'(`CPE_CUR_DIV);  // RULE1
    cur_calc_c  = cur_quo_c[15:0];  // RULE15
    cur_abs_c   = cur_last_ff[15] ? 16'(-cur_last_ff) : cur_last_ff;
    pwr_prod_c  = {15'h0000, cur_abs_c} * {16'h0000, rail_sense_code};  // RULE15
    pwr_quo_c   = pwr_prod_c / 31'(`CPE_PWR_DIV);  // RULE2
    pwr_calc_c  = pwr_quo_c[15:0];  // RULE15
    avg_shift_c = avg_log2(cfg_ff[`CPE_CFG_AVG_LSB +: 3]);
    last_cnt_c  = AVG_BITS'((32'h1 << avg_shift_c) - 32'h1);
    shunt_sum_c = shunt_acc_ff + AW'($signed(shunt_code));
    cur_sum_c   = cur_acc_ff + AW'($signed(cur_calc_c));
    rail_sum_c  = rail_acc_ff + AW'(rail_sense_code);
    pwr_sum_c   = pwr_acc_ff + AW'(pwr_calc_c);
    shunt_avg_c = shunt_acc_ff >>> avg_shift_c;  // RULE14
    cur_avg_c   = cur_acc_ff >>> avg_shift_c;  // RULE14
    rail_avg_c  = rail_sum_c >> avg_shift_c;  // RULE14
    pwr_avg_c   = pwr_sum_c >> avg_shift_c;  // RULE14
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    nxt_cfg       = cfg_ff;
    nxt_scale     = scale_ff;
    nxt_shunt_reg = shunt_reg_ff;
    nxt_rail_reg  = rail_reg_ff;
    nxt_current   = current_ff;
    nxt_power     = power_ff;
    nxt_cur_last  = cur_last_ff;
    nxt_shunt_acc = shunt_acc_ff;
    nxt_cur_acc   = cur_acc_ff;
    nxt_rail_acc  = rail_acc_ff;
    nxt_pwr_acc   = pwr_acc_ff;
    nxt_cnt       = cnt_ff;
    nxt_loaded    = 1'b0;
    nxt_rd_valid  = reg_rd_en;
    nxt_rd_data   = rd_data_ff;

    // Shunt sample: current is formed now from the shunt code.
    if (shunt_done) begin  // RULE13
      nxt_cur_last  = cur_calc_c;  // RULE5
      nxt_shunt_acc = shunt_sum_c;  // RULE8
      nxt_cur_acc   = cur_sum_c;  // RULE14
    end

    // Rail sample: power uses the previous current and closes one sample.
    if (rail_done) begin  // RULE13
      nxt_rail_acc = rail_sum_c;  // RULE6
      nxt_pwr_acc  = pwr_sum_c;  // RULE14
      nxt_cnt      = cnt_ff + 1'b1;
      if (cnt_ff == last_cnt_c) begin  // RULE14
        nxt_shunt_reg = shunt_avg_c[15:0];
        nxt_rail_reg  = {1'b0, rail_avg_c[14:0]};  // RULE7
        nxt_current   = cur_avg_c[15:0];
        nxt_power     = pwr_avg_c[15:0];
        // A shunt sample that lands with the closing rail sample opens the next block.
        nxt_shunt_acc = shunt_done ? AW'($signed(shunt_code)) : '0;  // RULE14
        nxt_cur_acc   = shunt_done ? AW'($signed(cur_calc_c)) : '0;
        nxt_rail_acc  = '0;
        nxt_pwr_acc   = '0;
        nxt_cnt       = '0;
        nxt_loaded    = 1'b1;
      end
    end

    // Host writes; result registers ignore writes.
    if (reg_wr_en) begin  // RULE16
      unique case (reg_addr)
        `CPE_ADDR_CFG: begin  // RULE10
          nxt_cfg       = reg_wr_data;
          nxt_shunt_acc = '0;
          nxt_cur_acc   = '0;
          nxt_rail_acc  = '0;
          nxt_pwr_acc   = '0;
          nxt_cnt       = '0;
        end
        `CPE_ADDR_SCALE: nxt_scale = reg_wr_data;  // RULE5
        default: ;
      endcase
    end

    // Results stay zero until a nonzero scale factor exists.
    if (nxt_scale == 16'h0000) begin  // RULE4
      nxt_current  = 16'h0000;
      nxt_power    = 16'h0000;
      nxt_cur_last = 16'h0000;
    end

    if (reg_rd_en) begin  // RULE9
      unique case (reg_addr)
        `CPE_ADDR_CFG:     nxt_rd_data = cfg_ff;
        `CPE_ADDR_SHUNT:   nxt_rd_data = shunt_reg_ff;
        `CPE_ADDR_RAIL:    nxt_rd_data = rail_reg_ff;
        `CPE_ADDR_POWER:   nxt_rd_data = power_ff;
        `CPE_ADDR_CURRENT: nxt_rd_data = current_ff;
        `CPE_ADDR_SCALE:   nxt_rd_data = scale_ff;
        default:           nxt_rd_data = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_ff       <= `CPE_CFG_RESET;
      scale_ff     <= `CPE_SCALE_RESET;
      shunt_reg_ff <= 16'h0000;
      rail_reg_ff  <= 16'h0000;
      current_ff   <= 16'h0000;
      power_ff     <= 16'h0000;
      cur_last_ff  <= 16'h0000;
      shunt_acc_ff <= '0;
      cur_acc_ff   <= '0;
      rail_acc_ff  <= '0;
      pwr_acc_ff   <= '0;
      cnt_ff       <= '0;
      rd_data_ff   <= 16'h0000;
      rd_valid_ff  <= 1'b0;
      loaded_ff    <= 1'b0;
    end else begin
      cfg_ff       <= nxt_cfg;
      scale_ff     <= nxt_scale;
      shunt_reg_ff <= nxt_shunt_reg;
      rail_reg_ff  <= nxt_rail_reg;
      current_ff   <= nxt_current;
      power_ff     <= nxt_power;
      cur_last_ff  <= nxt_cur_last;
      shunt_acc_ff <= nxt_shunt_acc;
      cur_acc_ff   <= nxt_cur_acc;
      rail_acc_ff  <= nxt_rail_acc;
      pwr_acc_ff   <= nxt_pwr_acc;
      cnt_ff       <= nxt_cnt;
      rd_data_ff   <= nxt_rd_data;
      rd_valid_ff  <= nxt_rd_valid;
      loaded_ff    <= nxt_loaded;
    end
  end

  assign reg_rd_data    = rd_data_ff;
  assign reg_rd_valid   = rd_valid_ff;
  assign results_loaded = loaded_ff;
  assign shunt_ct_sel   = cfg_ff[`CPE_CFG_SCT_LSB +: 3];  // RULE10
  assign rail_ct_sel    = cfg_ff[`CPE_CFG_RCT_LSB +: 3];  // RULE10
  assign avg_sel        = cfg_ff[`CPE_CFG_AVG_LSB +: 3];  // RULE10
  assign op_mode        = cfg_ff[`CPE_CFG_MODE_LSB +: 3];

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_last_rail;
    rail_done && !reg_wr_en && cnt_ff == last_cnt_c && scale_ff != 16'h0000;
  endsequence

  sequence s_mid_rail;
    rail_done && cnt_ff != last_cnt_c;
  endsequence

  zero_results_a: assert property (scale_ff == 16'h0000 |->  // RULE4
      current_ff == 16'h0000 && power_ff == 16'h0000)
    else $error("results not zero without scale factor");
  rail_msb_a: assert property (rail_reg_ff[15] == 1'b0)  // RULE7
    else $error("rail result top bit set");
  cur_calc_a: assert property (shunt_done && !reg_wr_en |=>  // RULE1
      cur_last_ff == 16'(($signed($past(shunt_code)) * $signed({1'b0, scale_ff})) / 2048))
    else $error("current product wrong");
  pwr_load_a: assert property ((s_last_rail and avg_sel == 3'h0) |=>  // RULE2
      power_ff == 16'(($past(cur_abs_c) * $past(rail_sense_code)) / 20000))
    else $error("power product wrong");
  mid_hold_a: assert property ((s_mid_rail and !reg_wr_en && scale_ff != 16'h0000) |=>  // RULE14
      $stable(current_ff) && $stable(power_ff) && !results_loaded)
    else $error("results changed before averaging finished");
  cfg_write_a: assert property (reg_wr_en && reg_addr == `CPE_ADDR_CFG |=>  // RULE10
      avg_sel == $past(reg_wr_data[11:9]) && shunt_ct_sel == $past(reg_wr_data[5:3]))
    else $error("config fields not taken");
  ro_write_a: assert property (reg_wr_en && !rail_done &&  // RULE16
      reg_addr == `CPE_ADDR_CURRENT |=> $stable(current_ff))
    else $error("read-only register written");
  scale_read_a: assert property (reg_rd_en && reg_addr == `CPE_ADDR_SCALE |=>  // RULE9
      reg_rd_valid && reg_rd_data == $past(scale_ff))
    else $error("scale read wrong");
  // Back-to-back block ends may keep the pulse high for one more cycle.
  load_pulse_a: assert property (s_last_rail |=>  // RULE5
      results_loaded ##1 (!results_loaded || $past(rail_done)))
    else $error("load pulse missing");

endmodule  // cpe_engine

`default_nettype wire

// *** hw/cpe_pkg.sv ***
// Shared types of the current and power scaling engine.
package cpe_pkg;
  typedef logic [15:0] cpe_word_t;
  typedef logic [2:0]  cpe_sel_t;
endpackage

// *** verification/cpe_sample_src.sv ***
// Converter-side model that delivers shunt and rail samples.
`timescale 1ns/1ps
`default_nettype none

module cpe_sample_src (
  input  wire logic        core_clk,
  output logic             shunt_done,
  output logic [15:0]      shunt_code,
  output logic             rail_done,
  output logic [14:0]      rail_sense_code
);
  initial begin
    shunt_done = 1'b0;
    rail_done = 1'b0;
    shunt_code = 16'h0000;
    rail_sense_code = 15'h0000;
  end

  // Outside a pulse the codes show the inverse of the last value, so stale data never matches.
  task automatic sample(input logic [15:0] sh, input logic [14:0] rl, input int gap);
    @(posedge core_clk);
    shunt_done <= 1'b1;
    shunt_code <= sh;
    @(posedge core_clk);
    shunt_done <= 1'b0;
    shunt_code <= ~sh;
    repeat (gap) @(posedge core_clk);
    rail_done <= 1'b1;
    rail_sense_code <= rl;
    @(posedge core_clk);
    rail_done <= 1'b0;
    rail_sense_code <= ~rl;
  endtask
endmodule // cpe_sample_src

`default_nettype wire

// *** verification/test_current_power_scaling_engine.sv ***
// Self-checking bench of the current and power scaling engine.
`timescale 1ns/1ps
`default_nettype none

module test_current_power_scaling_engine;
  logic              core_clk;
  logic              reset_n;
  logic [7:0]        reg_addr;
  logic              reg_wr_en;
  logic [15:0]       reg_wr_data;
  logic              reg_rd_en;
  logic [15:0]       reg_rd_data;
  logic              reg_rd_valid;
  logic              shunt_done;
  logic [15:0]       shunt_code;
  logic              rail_done;
  logic [14:0]       rail_sense_code;
  cpe_pkg::cpe_sel_t shunt_ct_sel;
  cpe_pkg::cpe_sel_t rail_ct_sel;
  cpe_pkg::cpe_sel_t avg_sel;
  cpe_pkg::cpe_sel_t op_mode;
  logic              results_loaded;
  int                err_total;
  int                n_compared;

  cpe_engine #(.AVG_BITS(10)) dut (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid), .shunt_done(shunt_done), .shunt_code(shunt_code),
    .rail_done(rail_done), .rail_sense_code(rail_sense_code), .shunt_ct_sel(shunt_ct_sel),
    .rail_ct_sel(rail_ct_sel), .avg_sel(avg_sel), .op_mode(op_mode),
    .results_loaded(results_loaded)
  );

  cpe_sample_src src (
    .core_clk(core_clk), .shunt_done(shunt_done), .shunt_code(shunt_code),
    .rail_done(rail_done), .rail_sense_code(rail_sense_code)
  );

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic wrap_up();
    if (err_total == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= 1'b1;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    #1;
    chk(16'(reg_rd_valid), 16'h0001);
    chk(reg_rd_data, exp);
  endtask

  // The load pulse stands for one cycle right after the closing rail sample.
  task automatic wait_loaded();
    int i = 0;
    #1;
    while (results_loaded !== 1'b1 && i < 20) begin
      @(posedge core_clk);
      #1;
      i++;
    end
    chk(16'(results_loaded), 16'h0001);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    rd_chk(8'h00, 16'h4127);
    rd_chk(8'h05, 16'h0000);
    rd_chk(8'h04, 16'h0000);
    rd_chk(8'h03, 16'h0000);
    rd_chk(8'h06, 16'h0000);
    chk(16'({avg_sel, rail_ct_sel, shunt_ct_sel, op_mode}), 16'h0127);
  endtask

  task automatic t_uncal();
    src.sample(16'h1f40, 15'h2570, 1);
    wait_loaded();
    rd_chk(8'h04, 16'h0000);
    rd_chk(8'h03, 16'h0000);
    rd_chk(8'h01, 16'h1f40);
    rd_chk(8'h02, 16'h2570);
  endtask

  task automatic t_cal();
    wr(8'h05, 16'h0a00);
    rd_chk(8'h05, 16'h0a00);
    src.sample(16'h1f40, 15'h2570, 1);
    wait_loaded();
    rd_chk(8'h04, 16'h2710);
    rd_chk(8'h03, 16'h12b8);
    wr(8'h04, 16'hffff);
    rd_chk(8'h04, 16'h2710);
    // Host trims the factor for a measured 9900 against a reported 10000.
    wr(8'h05, 16'h09e6);
    src.sample(16'h1f40, 15'h2570, 1);
    wait_loaded();
    rd_chk(8'h04, 16'h26aa);
    rd_chk(8'h03, 16'h1287);
    wr(8'h05, 16'h0a00);
  endtask

  task automatic t_neg_max();
    src.sample(16'he0c0, 15'h7fff, 1);
    wait_loaded();
    rd_chk(8'h04, 16'hd8f0);
    rd_chk(8'h03, 16'h3fff);
    rd_chk(8'h02, 16'h7fff);
  endtask

  task automatic t_avg();
    wr(8'h00, 16'h42ab);
    rd_chk(8'h00, 16'h42ab);
    chk(16'({avg_sel, rail_ct_sel, shunt_ct_sel, op_mode}), 16'h02ab);
    src.sample(16'h0fa0, 15'h2570, 1);
    src.sample(16'h0fa0, 15'h2570, 6);
    src.sample(16'h1f40, 15'h2570, 1);
    repeat (4) @(posedge core_clk);
    rd_chk(8'h04, 16'hd8f0);
    src.sample(16'h1f40, 15'h2570, 0);
    wait_loaded();
    rd_chk(8'h04, 16'h1d4c);
    rd_chk(8'h03, 16'h0e0a);
    rd_chk(8'h01, 16'h1770);
  endtask

  // ------------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  initial begin
    err_total = 0;
    n_compared = 0;
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 16'h0000;
    reg_rd_en = 1'b0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset();
    t_uncal();
    t_cal();
    t_neg_max();
    t_avg();
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    wrap_up();
  end
endmodule // test_current_power_scaling_engine

`default_nettype wire
